/* File: core/mem_access.sv */
/*
 Table read sequencing, data memory decode and indirect addressing for a
 small 8-bit core.
 Assumes the decoder issues one access per cycle and holds a table read
 request until table_busy drops; program memory answers within a cycle.
*/
`timescale 1ns/1ps
`include "mem_access_regs.svh"

// What this block does
// [R1] Larger variants branch to 010H on converter done if enabled, stack free
// [R2] Table pointer gives low eight bits of every table address
// [R3] Current page read uses upper program counter bits plus table pointer
// [R4] Last page read forces upper address bits to ones
// [R5] Low byte of fetched word goes to the operand location if it lies in the general area
// [R6] Upper word part goes to table high byte, unused bits zero
// [R7] Table high byte is read-only, changed only by table reads
// [R8] Software should mask interrupts around main-line table reads
// [R9] Each table read takes two instruction cycles
// [R10] Table address width is twelve, eleven or ten bits per variant
// [R11] Data memory is byte wide from 00H, special then general area
// [R12] Shared special registers sit at the same address in all variants
// [R13] General locations read, write, and single-bit set or clear
// [R14] Unused and gap addresses read 00H
// [R15] Protected special registers ignore software writes
// [R16] Indirect ports hold nothing and redirect to their pointer
// [R17] Port zero pairs with pointer zero, port one with pointer one
// [R18] Pointer at an indirect port reads 00H, writes nothing
// [R19] Smaller variants read pointer bit 7 as one
// [R20] Second table cycle puts table address on program memory bus
module mem_access
   import mem_access_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Variant select, static
   input wire mem_access_pkg::variant_t variant,
   // Data memory access from the core
   input wire logic [7:0] dm_addr,
   input wire logic dm_rd,
   input wire logic dm_wr,
   input wire logic [7:0] dm_wdata,
   input wire logic dm_bit_set,
   input wire logic dm_bit_clr,
   input wire logic [2:0] dm_bit_sel,
   output logic [7:0] dm_rdata,
   // Table read request from the decoder
   input wire logic tbl_current,
   input wire logic tbl_last,
   input wire logic [7:0] tbl_dest,
   output logic table_busy,
   // Program counter and program memory
   input wire logic [11:0] pc,
   input wire logic [11:0] fetch_addr,
   output logic [11:0] prog_addr,
   input wire logic [14:0] prog_word,
   // Converter interrupt request
   input wire logic conv_done,
   input wire logic conv_irq_en,
   input wire logic stack_full,
   output logic vector_req,
   output logic [11:0] vector_addr
);
   // Sequencer state
   table_state_t state;
   table_state_t next_state;
   logic [11:0] tbl_addr;
   logic [11:0] next_tbl_addr;
   logic [7:0] tbl_dest_q;
   logic [7:0] next_tbl_dest_q;
   logic [11:0] next_prog_addr;
   logic next_table_busy;

   // Special registers held here
   logic [7:0] pointer_zero;
   logic [7:0] pointer_one;
   logic [7:0] table_pointer;
   logic [7:0] table_high_byte;
   logic [7:0] next_pointer_zero;
   logic [7:0] next_pointer_one;
   logic [7:0] next_table_pointer;
   logic [7:0] next_table_high_byte;
   logic [7:0] next_dm_rdata;
   logic next_vector_req;
   logic [11:0] next_vector_addr;
   logic conv_pend;
   logic next_conv_pend;

   // Effective address and decode
   logic [7:0] eff_addr;
   logic via_port;
   logic port_self;
   logic [8:0] gp_size;
   logic [8:0] gp_offset;
   logic in_gp;
   logic [7:0] gp_index;
   logic [7:0] gp_rdata;
   logic gp_wr;
   logic gp_set;
   logic gp_clr;
   logic [7:0] gp_wdata;
   logic [7:0] table_mask;
   logic [7:0] special_rd;
   logic [7:0] wr_val;
   logic [7:0] ptr_bit7;
   logic [6:0] high_part;

   // [R16] [R17] Indirect port redirect through its paired pointer
   always_comb begin
      via_port = 1'b0;
      eff_addr = dm_addr;
      if (dm_addr == `ADDR_INDIRECT_ZERO) begin
         via_port = 1'b1;
         eff_addr = pointer_zero;
      end else if (dm_addr == `ADDR_INDIRECT_ONE) begin
         via_port = 1'b1;
         eff_addr = pointer_one;
      end
      // [R18] Pointer aimed at a port
      port_self = via_port && (eff_addr == `ADDR_INDIRECT_ZERO ||
                               eff_addr == `ADDR_INDIRECT_ONE);
   end

   // [R11] General area starts at GP_START, after a gap above the special area
   always_comb begin
      case (variant)
         VARIANT_SMALL: gp_size = `GP_SIZE_SMALL;
         VARIANT_MIDDLE: gp_size = `GP_SIZE_MIDDLE;
         VARIANT_LARGE: gp_size = `GP_SIZE_LARGE;
         default: gp_size = `GP_SIZE_SMALL;
      endcase
      gp_offset = {1'b0, eff_addr} - {1'b0, `GP_START};
      in_gp = (eff_addr >= `GP_START) && (gp_offset < gp_size);
      gp_index = gp_offset[7:0];
   end

   // [R19] Top pointer bit reads one on smaller variants
   always_comb begin
      ptr_bit7 = (variant == VARIANT_LARGE) ? 8'h00 : 8'h80;
      // [R10] Upper table address bits by variant
      case (variant)
         VARIANT_SMALL: table_mask = 8'h03;
         VARIANT_MIDDLE: table_mask = 8'h07;
         VARIANT_LARGE: table_mask = 8'h0F;
         default: table_mask = 8'h03;
      endcase
   end

   // [R12] [R14] Fixed special addresses, unused ones read zero
   always_comb begin
      case (eff_addr)
         `ADDR_POINTER_ZERO: special_rd = pointer_zero | ptr_bit7;
         `ADDR_POINTER_ONE: special_rd = pointer_one | ptr_bit7;
         `ADDR_TABLE_POINTER: special_rd = table_pointer;
         `ADDR_TABLE_HIGH: special_rd = table_high_byte;
         default: special_rd = `DATA_ZERO;
      endcase
   end

   // Value after a byte write or a single bit change
   always_comb begin
      wr_val = dm_wdata;
      if (dm_bit_set) begin
         wr_val = special_rd | (8'h01 << dm_bit_sel);
      end else if (dm_bit_clr) begin
         wr_val = special_rd & ~(8'h01 << dm_bit_sel);
      end
   end

   // General area write strobes; table result also lands here
   always_comb begin
      gp_wr = 1'b0;
      gp_set = 1'b0;
      gp_clr = 1'b0;
      gp_wdata = dm_wdata;
      if (state == TBL_FETCH) begin
         // [R5] Low byte to the operand location
         gp_wr = in_gp && !port_self;
         gp_wdata = prog_word[7:0];
      end else if (!port_self && in_gp) begin
         gp_wr = dm_wr;
         gp_set = dm_bit_set;
         gp_clr = dm_bit_clr;
      end
   end

   gp_ram u_gp_ram (
      .clk(clk),
      .index(gp_index),
      .wr_en(gp_wr),
      .wr_data(gp_wdata),
      .bit_set(gp_set),
      .bit_clr(gp_clr),
      .bit_sel(dm_bit_sel),
      .rd_data(gp_rdata)
   );

   // Register writes and read data
   always_comb begin
      next_pointer_zero = pointer_zero;
      next_pointer_one = pointer_one;
      next_table_pointer = table_pointer;
      next_table_high_byte = table_high_byte;
      next_dm_rdata = dm_rdata;
      high_part = prog_word[14:8];
      // [R6] Word width 14 leaves the top bit zero
      if (variant != VARIANT_LARGE) begin
         high_part[6] = 1'b0;
      end
      if (state == TBL_FETCH) begin
         // [R7] Only the table read loads the high byte
         next_table_high_byte = {1'b0, high_part};
      end else if ((dm_wr || dm_bit_set || dm_bit_clr) && !port_self) begin
         // [R15] Table high byte not in this list, so writes drop
         case (eff_addr)
            `ADDR_POINTER_ZERO: next_pointer_zero = wr_val;
            `ADDR_POINTER_ONE: next_pointer_one = wr_val;
            `ADDR_TABLE_POINTER: next_table_pointer = wr_val;
            default: next_table_pointer = table_pointer;
         endcase
      end
      if (dm_rd) begin
         if (port_self) begin
            next_dm_rdata = `DATA_ZERO;
         end else if (in_gp) begin
            next_dm_rdata = gp_rdata;
         end else begin
            next_dm_rdata = special_rd;
         end
      end
   end

   // Table read sequencer; the operand rides on dm_addr in cycle two
   always_comb begin
      next_state = state;
      next_tbl_addr = tbl_addr;
      next_tbl_dest_q = tbl_dest_q;
      next_table_busy = 1'b0;
      next_prog_addr = fetch_addr;
      case (state)
         TBL_IDLE: begin
            if (tbl_current || tbl_last) begin
               // [R2] [R3] [R4] Table address forms
               if (tbl_last) begin
                  next_tbl_addr = {{4{1'b1}}, table_pointer};
               end else begin
                  next_tbl_addr = {pc[11:8], table_pointer};
               end
               next_tbl_addr[11:8] = next_tbl_addr[11:8] & table_mask[3:0];
               next_tbl_dest_q = tbl_dest;
               // [R20] Table address replaces the fetch
               next_prog_addr = next_tbl_addr;
               next_table_busy = 1'b1;
               next_state = TBL_FETCH;
            end
         end
         TBL_FETCH: begin
            // [R9] Second cycle retires the read
            next_state = TBL_DONE;
         end
         TBL_DONE: begin
            next_state = TBL_IDLE;
         end
         default: next_state = TBL_IDLE;
      endcase
   end

   // [R1] Converter vector with enable and stack guard
   always_comb begin
      next_conv_pend = conv_pend | conv_done;
      next_vector_req = 1'b0;
      next_vector_addr = vector_addr;
      // One pulse at a time; a fresh done in the taken cycle stays pending only when an earlier done was already pending
      if (variant != VARIANT_SMALL && next_conv_pend && conv_irq_en &&
          !stack_full && !next_table_busy && state == TBL_IDLE &&
          !vector_req) begin
         next_vector_req = 1'b1;
         next_vector_addr = `CONVERTER_VECTOR;
         next_conv_pend = conv_pend & conv_done;
      end
   end

   // Registered state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= TBL_IDLE;
         tbl_addr <= 12'h000;
         tbl_dest_q <= 8'h00;
         prog_addr <= 12'h000;
         table_busy <= 1'b0;
         pointer_zero <= 8'h00;
         pointer_one <= 8'h00;
         table_pointer <= 8'h00;
         table_high_byte <= 8'h00;
         dm_rdata <= 8'h00;
         conv_pend <= 1'b0;
         vector_req <= 1'b0;
         vector_addr <= 12'h000;
      end else begin
         state <= next_state;
         tbl_addr <= next_tbl_addr;
         tbl_dest_q <= next_tbl_dest_q;
         prog_addr <= next_prog_addr;
         table_busy <= next_table_busy;
         pointer_zero <= next_pointer_zero;
         pointer_one <= next_pointer_one;
         table_pointer <= next_table_pointer;
         table_high_byte <= next_table_high_byte;
         dm_rdata <= next_dm_rdata;
         conv_pend <= next_conv_pend;
         vector_req <= next_vector_req;
         vector_addr <= next_vector_addr;
      end
   end
endmodule : mem_access

/* File: core/mem_access_regs.svh */
/*
 Holds the data memory map, table address widths and vector constants
 for the memory access block.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef MEM_ACCESS_REGS_SVH
`define MEM_ACCESS_REGS_SVH

// Special register addresses, shared by every variant
`define ADDR_INDIRECT_ZERO 8'h00
`define ADDR_POINTER_ZERO 8'h01
`define ADDR_INDIRECT_ONE 8'h02
`define ADDR_POINTER_ONE 8'h03
`define ADDR_ACC 8'h05
`define ADDR_PCL 8'h06
`define ADDR_TABLE_POINTER 8'h07
`define ADDR_TABLE_HIGH 8'h08
`define ADDR_STATUS 8'h0A

// General purpose area start and size per variant
`define GP_START 8'h40
`define GP_SIZE_SMALL 9'h040
`define GP_SIZE_MIDDLE 9'h060
`define GP_SIZE_LARGE 9'h0A0
`define GP_DEPTH 160

// Table address widths per variant
`define TABLE_AW_SMALL 10
`define TABLE_AW_MIDDLE 11
`define TABLE_AW_LARGE 12

// Program word widths per variant
`define WORD_W_SMALL 14
`define WORD_W_LARGE 15

// Converter vector on the two larger variants
`define CONVERTER_VECTOR 12'h010

// Reset and fixed read values
`define DATA_ZERO 8'h00
`define POINTER_TOP_BIT 7
`define STATUS_FLAG_MASK 8'h30

`endif

/* File: core/mem_access_pkg.sv */
/*
 Types for the memory access block.
 Assumes the constants header sits in the same include path.
*/
package mem_access_pkg;
`include "mem_access_regs.svh"

   // Device variant
   typedef enum logic [1:0] {
      VARIANT_SMALL = 2'h0,
      VARIANT_MIDDLE = 2'h1,
      VARIANT_LARGE = 2'h2
   } variant_t;

   // Table read sequencer, one-hot
   typedef enum logic [2:0] {
      TBL_IDLE = 3'h1,
      TBL_FETCH = 3'h2,
      TBL_DONE = 3'h4
   } table_state_t;

   typedef logic [11:0] prog_addr_t;
   typedef logic [7:0] data_t;
endpackage : mem_access_pkg

/* File: core/gp_ram.sv */
/*
 General purpose data memory array with bit set and clear.
 Assumes the parent has already range-checked the index.
*/
`timescale 1ns/1ps
`include "mem_access_regs.svh"

module gp_ram (
   // Clock
   input wire logic clk,
   // Access
   input wire logic [7:0] index,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic bit_set,
   input wire logic bit_clr,
   input wire logic [2:0] bit_sel,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:`GP_DEPTH-1];
   logic [7:0] bit_mask;
   logic [7:0] word_now;

   // Asynchronous read so the core sees data within the cycle
   always_comb begin
      word_now = mem[index];
      bit_mask = 8'h01 << bit_sel;
      rd_data = word_now;
   end

   // [R13] Byte write and single bit change
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[index] <= wr_data;
      end else if (bit_set) begin
         mem[index] <= word_now | bit_mask;
      end else if (bit_clr) begin
         mem[index] <= word_now & ~bit_mask;
      end
   end
endmodule : gp_ram

/* File: dv/mem_access_props.sv */
/*
 Port assertions for mem_access.
 Assumes it is bound onto every mem_access instance.
*/
`timescale 1ns/1ps
module mem_access_props
   import mem_access_pkg::*;
(
   // Clock, reset, variant
   input wire logic clk,
   input wire logic nrst,
   input wire mem_access_pkg::variant_t variant,
   // Data side
   input wire logic [7:0] dm_addr,
   input wire logic dm_rd,
   input wire logic [7:0] dm_rdata,
   // Table side
   input wire logic tbl_current,
   input wire logic tbl_last,
   input wire logic table_busy,
   input wire logic [11:0] pc,
   input wire logic [11:0] fetch_addr,
   input wire logic [11:0] prog_addr,
   // Vector side
   input wire logic conv_irq_en,
   input wire logic stack_full,
   input wire logic vector_req,
   input wire logic [11:0] vector_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic was_busy;
   logic take;
   logic [3:0] top;
   // Done cycle follows busy; requests there are refused
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         was_busy <= 1'b0;
      end else begin
         was_busy <= table_busy;
      end
   end
   // Accepted request and upper address mask per variant
   assign take = (tbl_current | tbl_last) & !table_busy & !was_busy;
   assign top = (variant == VARIANT_SMALL) ? 4'h3 :
      (variant == VARIANT_MIDDLE) ? 4'h7 : 4'hF;
   sequence s_table;
      table_busy ##1 !table_busy;
   endsequence
   AST_TAKE: assert property (take |=> s_table)
      else $error("table cycle not one busy cycle");
   AST_BUSY_CAUSE: assert property ($rose(table_busy) |-> $past(take))
      else $error("busy without request");
   AST_LAST_PAGE: assert property (take && tbl_last |=>
      prog_addr[11:8] == top) else $error("last page bits wrong");
   AST_CUR_PAGE: assert property (take && !tbl_last |=>
      prog_addr[11:8] == ($past(pc[11:8]) & top))
      else $error("current page bits wrong");
   AST_FETCH: assert property (!take |=>
      prog_addr == $past(fetch_addr)) else $error("fetch not passed");
   AST_GAP: assert property (dm_rd && dm_addr >= 8'h09 &&
      dm_addr <= 8'h3F |=> dm_rdata == 8'h00) else $error("gap not zero");
   AST_VEC_ADDR: assert property (vector_req |->
      vector_addr == 12'h010 && variant != VARIANT_SMALL)
      else $error("bad vector");
   AST_VEC_ONE: assert property (vector_req |=> !vector_req)
      else $error("vector longer than a cycle");
   AST_VEC_COND: assert property (vector_req |->
      $past(conv_irq_en) && !$past(stack_full)) else $error("vector blocked");
endmodule : mem_access_props

bind mem_access mem_access_props u_props (.clk(clk), .nrst(nrst),
   .variant(variant), .dm_addr(dm_addr), .dm_rd(dm_rd),
   .dm_rdata(dm_rdata), .tbl_current(tbl_current), .tbl_last(tbl_last),
   .table_busy(table_busy), .pc(pc), .fetch_addr(fetch_addr),
   .prog_addr(prog_addr), .conv_irq_en(conv_irq_en),
   .stack_full(stack_full), .vector_req(vector_req),
   .vector_addr(vector_addr));

/* File: dv/mem_access_tb_top.sv */
/*
 Self-checking bench for mem_access.
 Assumes the core files and the checker are compiled before it.
*/
`timescale 1ns/1ps
module mem_access_tb_top;
   import mem_access_pkg::*;
   // Stimulus, all set at time zero
   logic clk = 1'b0, nrst = 1'b0, dm_rd = 1'b0, dm_wr = 1'b0;
   logic dm_bit_set = 1'b0, dm_bit_clr = 1'b0, tbl_current = 1'b0;
   logic tbl_last = 1'b0, conv_done = 1'b0, conv_irq_en = 1'b0;
   logic stack_full = 1'b0;
   variant_t variant = VARIANT_LARGE;
   logic [7:0] dm_addr = 8'h00, dm_wdata = 8'h00, tbl_dest = 8'h00;
   logic [2:0] dm_bit_sel = 3'h0;
   logic [11:0] pc = 12'h3A0, fetch_addr = 12'h000;
   logic [14:0] prog_word = 15'h7A3C;
   // Observed
   logic [7:0] dm_rdata, d;
   logic table_busy, vector_req;
   logic [11:0] prog_addr, vector_addr;
   int err_total = 0, checked = 0, cycles = 0;
   localparam logic [3:0] W = 4'h8, R = 4'h4, S = 4'h2, C = 4'h1;

   mem_access u_dut (.clk(clk), .nrst(nrst), .variant(variant),
      .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
      .dm_bit_set(dm_bit_set), .dm_bit_clr(dm_bit_clr),
      .dm_bit_sel(dm_bit_sel), .dm_rdata(dm_rdata),
      .tbl_current(tbl_current), .tbl_last(tbl_last), .tbl_dest(tbl_dest),
      .table_busy(table_busy), .pc(pc), .fetch_addr(fetch_addr),
      .prog_addr(prog_addr), .prog_word(prog_word), .conv_done(conv_done),
      .conv_irq_en(conv_irq_en), .stack_full(stack_full),
      .vector_req(vector_req), .vector_addr(vector_addr));

   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end
   // Hang guard, far above the hundred or so cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 3000) begin
         err_total++;
         finish_test();
      end
   end

   // Fetch address moves every cycle so a stuck mux shows
   task tick();
      @(posedge clk);
      #5;
      fetch_addr = fetch_addr + 12'h001;
   endtask : tick
   task chk(string n, logic [14:0] e, logic [14:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Strobes stay until the next access, so none toggles twice a step
   task acc(logic [7:0] a, logic [7:0] v, logic [3:0] op);
      {dm_wr, dm_rd, dm_bit_set, dm_bit_clr} = op;
      dm_addr = a;
      dm_wdata = v;
      dm_bit_sel = v[2:0];
      tick();
      d = dm_rdata;
   endtask : acc
   task rdc(string n, logic [7:0] a, logic [7:0] e);
      acc(a, 8'h00, R);
      chk(n, e, d);
   endtask : rdc
   task rst(variant_t v);
      nrst = 1'b0;
      variant = v;
      repeat (4) tick();
      nrst = 1'b1;
   endtask : rst
   // Request held into busy and done cycles must be refused
   task tbl(logic last, logic [7:0] dst, logic [11:0] ea, logic [7:0] lo,
      logic [7:0] hi);
      {dm_wr, dm_rd, dm_bit_set, dm_bit_clr} = 4'h0;
      tbl_last = last;
      tbl_current = !last;
      tbl_dest = dst;
      tick();
      tbl_last = 1'b1;
      tbl_current = 1'b1;
      dm_addr = dst;
      chk("busy", 1, table_busy);
      chk("table addr", ea, prog_addr);
      tick();
      chk("busy end", 0, table_busy);
      chk("fetch back", fetch_addr - 12'h001, prog_addr);
      tick();
      tbl_last = 1'b0;
      tbl_current = 1'b0;
      chk("refused", 0, table_busy);
      rdc("low byte", dst, lo);
      rdc("high byte", 8'h08, hi);
   endtask : tbl

   task t_reset();
      rst(VARIANT_LARGE);
      chk("busy rst", 0, table_busy);
      chk("vec rst", 0, vector_req);
      rdc("high rst", 8'h08, 8'h00);
   endtask : t_reset
   task t_gp();
      acc(8'h40, 8'hA5, W);
      rdc("gp", 8'h40, 8'hA5);
      acc(8'h40, 8'h01, S);
      rdc("bit set", 8'h40, 8'hA7);
      acc(8'h40, 8'h07, C);
      rdc("bit clr", 8'h40, 8'h27);
      acc(8'hDF, 8'h3C, W);
      rdc("gp top", 8'hDF, 8'h3C);
   endtask : t_gp
   task t_gap();
      acc(8'h20, 8'h5A, W);
      rdc("gap", 8'h20, 8'h00);
      rdc("gap low", 8'h09, 8'h00);
      rdc("beyond", 8'hE0, 8'h00);
      acc(8'h08, 8'hFF, W);
      rdc("high ro", 8'h08, 8'h00);
   endtask : t_gap
   task t_ind();
      acc(8'h01, 8'hC1, W);
      acc(8'h03, 8'h42, W);
      acc(8'h00, 8'h11, W);
      acc(8'h02, 8'h22, W);
      rdc("via ptr0", 8'hC1, 8'h11);
      rdc("via ptr1", 8'h42, 8'h22);
      rdc("port1", 8'h02, 8'h22);
      rdc("ptr0 large", 8'h01, 8'hC1);
      acc(8'h01, 8'h00, W);
      rdc("self", 8'h00, 8'h00);
      acc(8'h01, 8'h02, W);
      acc(8'h00, 8'h77, W);
      rdc("no write", 8'h42, 8'h22);
   endtask : t_ind
   task t_tbl();
      // Converter interrupt masked around table reads
      conv_irq_en = 1'b0;
      acc(8'h07, 8'h06, W);
      tbl(1'b0, 8'h45, 12'h306, 8'h3C, 8'h7A);
      acc(8'h07, 8'h05, W);
      tbl(1'b1, 8'h46, 12'hF05, 8'h3C, 8'h7A);
   endtask : t_tbl
   task t_vec();
      conv_irq_en = 1'b1;
      stack_full = 1'b1;
      conv_done = 1'b1;
      tick();
      conv_done = 1'b0;
      repeat (4) tick();
      chk("vec full", 0, vector_req);
      stack_full = 1'b0;
      for (int i = 0; i < 4 && vector_req !== 1'b1; i++) tick();
      chk("vec", 1, vector_req);
      chk("vec addr", 12'h010, vector_addr);
      conv_irq_en = 1'b0;
      conv_done = 1'b1;
      tick();
      conv_done = 1'b0;
      repeat (4) tick();
      chk("vec masked", 0, vector_req);
   endtask : t_vec
   task t_small();
      rst(VARIANT_SMALL);
      acc(8'h01, 8'h41, W);
      rdc("ptr bit7", 8'h01, 8'hC1);
      acc(8'h7F, 8'h96, W);
      rdc("small top", 8'h7F, 8'h96);
      acc(8'h80, 8'h96, W);
      rdc("small beyond", 8'h80, 8'h00);
      acc(8'h07, 8'h06, W);
      tbl(1'b1, 8'h45, 12'h306, 8'h3C, 8'h3A);
      conv_irq_en = 1'b1;
      conv_done = 1'b1;
      tick();
      conv_done = 1'b0;
      repeat (4) tick();
      chk("vec small", 0, vector_req);
   endtask : t_small
   // Middle variant: its own area size, page width and vector
   task t_middle();
      // Converter interrupt masked around table reads
      conv_irq_en = 1'b0;
      rst(VARIANT_MIDDLE);
      acc(8'h03, 8'h15, W);
      rdc("ptr1 bit7", 8'h03, 8'h95);
      acc(8'h9F, 8'h6B, W);
      rdc("mid top", 8'h9F, 8'h6B);
      acc(8'hA0, 8'h6B, W);
      rdc("mid beyond", 8'hA0, 8'h00);
      acc(8'h07, 8'h06, W);
      tbl(1'b1, 8'h50, 12'h706, 8'h3C, 8'h3A);
      // Page bit above the eleven-bit range must be dropped
      pc = 12'hBA0;
      acc(8'h07, 8'h07, W);
      tbl(1'b0, 8'h51, 12'h307, 8'h3C, 8'h3A);
      conv_irq_en = 1'b1;
      conv_done = 1'b1;
      tick();
      conv_done = 1'b0;
      for (int i = 0; i < 4 && vector_req !== 1'b1; i++) tick();
      chk("vec mid", 1, vector_req);
      chk("vec mid addr", 12'h010, vector_addr);
   endtask : t_middle

   task finish_test();
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      t_reset();
      t_gp();
      t_gap();
      t_ind();
      t_tbl();
      t_vec();
      t_small();
      t_middle();
      finish_test();
   end
endmodule : mem_access_tb_top
